/* File: verilog/utic_cfg.svh */
`ifndef UTIC_CFG_SVH
`define UTIC_CFG_SVH
// Register address in data memory
`define UTIC_IRQ_CTRL_ADDR 8'h0B
// Field positions of irq_control_reg
`define UTIC_BIT_GIE 0
`define UTIC_BIT_UIE 1
`define UTIC_BIT_TIE 3
`define UTIC_BIT_UREQ 4
`define UTIC_BIT_TREQ 6
// Reset value of irq_control_reg
`define UTIC_IRQ_CTRL_RST 8'h00
// Field positions of usb_status_control
`define UTIC_USC_SUSPEND 0
`define UTIC_USC_BUSRST 2
`define UTIC_USC_RESUME 3
// Call vectors
`define UTIC_VEC_USB 11'h004
`define UTIC_VEC_TMR 11'h00C
// Phase-two divider count (core clock is four phases)
`define UTIC_PHASE_DIV 4
`endif

/* File: verilog/utic_pkg.sv */
package utic_pkg;
    typedef enum logic [1:0] {UTIC_SRC_NONE, UTIC_SRC_USB, UTIC_SRC_TMR} utic_src_t;
endpackage

/* File: verilog/utic_phase_div.sv */
`timescale 1ns/1ps
`include "utic_cfg.svh"
// ==========================================================
// Phase-two pulse divider
module utic_phase_div #(
    parameter int DIV = `UTIC_PHASE_DIV
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic phase_two_pulse
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    initial begin
        if (DIV < 2) $error("DIV must be at least 2");
    end
    logic [CW-1:0] cnt_q;
    wire last_w = (cnt_q == CW'(DIV - 1));
    // Free-running count, one pulse per core cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= last_w ? '0 : cnt_q + CW'(1);
        end
    end
    assign phase_two_pulse = last_w;
endmodule // utic_phase_div

/* File: verilog/utic_irq_ctrl.sv */
`timescale 1ns/1ps
`include "utic_cfg.svh"
// Contract
// RULE1 - Any USB event sets the USB request flag at bit 4
// RULE2 - Flag, source enable and free stack force a call to 04H
// RULE3 - USB entry clears its flag and the global enable together
// RULE4 - Host FIFO access sets its access bit and USB request; firmware clears
// RULE5 - Suspend from host sets status bit 0 and USB request
// RULE6 - Resume from host sets status bit 3 and USB request
// RULE7 - Bus reset sets bus reset flag and USB request; firmware clears
// RULE8 - Timer overflow sets the timer request flag at bit 6
// RULE9 - Timer request enabled with stack room calls 0CH, clearing flag and global
// RULE10 - Inside service, acknowledges wait for return-enable or software re-enable
// RULE11 - Return-enable sets global enable; plain return leaves it
// RULE12 - Requests are serviced on the next phase-two edge
// RULE13 - USB request wins over timer request
// RULE14 - Service needs global and source enable; otherwise only recorded
// RULE15 - Request flags hold until serviced or cleared by a write
// RULE16 - Control register sits at data address 0BH
// RULE17 - Firmware should avoid calls inside service routines
// RULE18 - Global enable bit 0, USB enable bit 1, timer enable bit 3
// RULE19 - Full stack blocks acknowledge until the pointer drops
// RULE20 - Only the program counter is pushed on vectoring
// RULE21 - Hardware set beats a simultaneous software clear
module utic_irq_ctrl
    import utic_pkg::*;
#(
    parameter int FIFOS = 2,
    parameter int ADDR_W = 8,
    parameter int PC_W = 11
) (
    input wire logic clk,
    input wire logic arst_n,
    // Data memory port of the core
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] irq_ctrl_rdata,
    output logic irq_ctrl_sel,
    // Firmware clears of USB status bits (one pulse per bit)
    input wire logic [FIFOS-1:0] fifo_flag_clr,
    input wire logic bus_reset_clr,
    input wire logic suspend_clr,
    input wire logic resume_clr,
    // USB engine events
    input wire logic [FIFOS-1:0] fifo_access,
    input wire logic usb_suspend,
    input wire logic usb_resume,
    input wire logic usb_bus_reset,
    // Timer
    input wire logic timer_overflow,
    // Core side
    input wire logic stack_full,
    input wire logic ret_enable_exec,
    input wire logic [PC_W-1:0] pc_cur,
    output logic irq_call,
    output logic [PC_W-1:0] irq_vector,
    output logic [PC_W-1:0] push_pc,
    output logic [FIFOS-1:0] fifo_access_flags,
    output logic [3:0] usb_status_control
);
    initial begin
        if (FIFOS < 1 || FIFOS > 8) $error("FIFOS out of range");
        if (PC_W < 4) $error("PC_W too small");
    end

    // ==========================================================
    // Phase-two timing
    logic phase_two_pulse;
    utic_phase_div #(.DIV(`UTIC_PHASE_DIV)) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .phase_two_pulse(phase_two_pulse)
    );

    // ==========================================================
    // Register decode
    logic gie_q, uie_q, tie_q, ureq_q, treq_q;
    logic [FIFOS-1:0] fifo_q;
    logic susp_q, res_q, brst_q;
    wire ctrl_hit_w = (mem_addr == ADDR_W'(`UTIC_IRQ_CTRL_ADDR)); // RULE16
    wire ctrl_wr_w = ctrl_hit_w && mem_wr;
    wire usb_event_w = (|fifo_access) || usb_suspend || usb_resume || usb_bus_reset; // RULE1

    // ==========================================================
    // Arbitration
    wire usb_rdy_w = ureq_q && uie_q && gie_q; // RULE14
    wire tmr_rdy_w = treq_q && tie_q && gie_q; // RULE14
    wire ack_w = phase_two_pulse && !stack_full && (usb_rdy_w || tmr_rdy_w); // RULE12 RULE19 RULE10
    utic_src_t src_w;
    assign src_w = !ack_w ? UTIC_SRC_NONE : (usb_rdy_w ? UTIC_SRC_USB : UTIC_SRC_TMR); // RULE13
    wire take_usb_w = (src_w == UTIC_SRC_USB);
    wire take_tmr_w = (src_w == UTIC_SRC_TMR);

    // Next state; an event set of a request flag wins over any clear, but entry clear of global wins over return-enable
    logic gie_d, uie_d, tie_d, ureq_d, treq_d;
    assign uie_d = ctrl_wr_w ? mem_wdata[`UTIC_BIT_UIE] : uie_q; // RULE18
    assign tie_d = ctrl_wr_w ? mem_wdata[`UTIC_BIT_TIE] : tie_q; // RULE18
    // Entry clears global; return-enable sets it
    assign gie_d = (src_w != UTIC_SRC_NONE) ? 1'b0 :
                   ret_enable_exec ? 1'b1 :
                   ctrl_wr_w ? mem_wdata[`UTIC_BIT_GIE] : gie_q; // RULE3 RULE9 RULE11
    assign ureq_d = usb_event_w ? 1'b1 :
                    take_usb_w ? 1'b0 :
                    ctrl_wr_w ? mem_wdata[`UTIC_BIT_UREQ] : ureq_q; // RULE21 RULE3 RULE15
    assign treq_d = timer_overflow ? 1'b1 :
                    take_tmr_w ? 1'b0 :
                    ctrl_wr_w ? mem_wdata[`UTIC_BIT_TREQ] : treq_q; // RULE8 RULE9 RULE15

    // Control register flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {treq_q, ureq_q, tie_q, uie_q, gie_q} <= 5'h00;
        end else begin
            {treq_q, ureq_q, tie_q, uie_q, gie_q} <= {treq_d, ureq_d, tie_d, uie_d, gie_d};
        end
    end

    // USB status bits: sticky until firmware clears; set wins
    wire [FIFOS-1:0] fifo_d = fifo_access | (fifo_q & ~fifo_flag_clr); // RULE4 RULE21
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_q <= '0;
            susp_q <= 1'b0;
            res_q <= 1'b0;
            brst_q <= 1'b0;
        end else begin
            fifo_q <= fifo_d;
            susp_q <= usb_suspend | (susp_q & ~suspend_clr); // RULE5
            res_q <= usb_resume | (res_q & ~resume_clr); // RULE6
            brst_q <= usb_bus_reset | (brst_q & ~bus_reset_clr); // RULE7
        end
    end

    // ==========================================================
    // Call request to core; only PC is pushed, status is not saved
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_call <= 1'b0;
            irq_vector <= '0;
            push_pc <= '0;
        end else begin
            irq_call <= ack_w;
            if (ack_w) begin
                irq_vector <= take_usb_w ? PC_W'(`UTIC_VEC_USB) : PC_W'(`UTIC_VEC_TMR); // RULE2 RULE9
                push_pc <= pc_cur; // RULE20
            end
        end
    end

    // Readback: unused bits read zero
    assign irq_ctrl_sel = ctrl_hit_w;
    always_comb begin
        irq_ctrl_rdata = `UTIC_IRQ_CTRL_RST;
        irq_ctrl_rdata[`UTIC_BIT_GIE] = gie_q;
        irq_ctrl_rdata[`UTIC_BIT_UIE] = uie_q;
        irq_ctrl_rdata[`UTIC_BIT_TIE] = tie_q;
        irq_ctrl_rdata[`UTIC_BIT_UREQ] = ureq_q;
        irq_ctrl_rdata[`UTIC_BIT_TREQ] = treq_q;
    end
    assign fifo_access_flags = fifo_q;
    always_comb begin
        usb_status_control = 4'h0;
        usb_status_control[`UTIC_USC_SUSPEND] = susp_q;
        usb_status_control[`UTIC_USC_BUSRST] = brst_q;
        usb_status_control[`UTIC_USC_RESUME] = res_q;
    end

    // ==========================================================
    // Checks

    // Cycles since the last phase pulse; a stalled divider would starve service
    logic [7:0] gap_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= phase_two_pulse ? 8'h00 : gap_q + 8'h01;
        end
    end

    // Event capture into the request flags, and flag hold
    a_usb_sets_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        usb_event_w |=> ureq_q)
        else $error("usb event lost");
    a_tmr_sets_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        timer_overflow |=> treq_q)
        else $error("timer event lost");
    a_set_beats_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE21
        ctrl_wr_w && usb_event_w |=> ureq_q)
        else $error("usb event lost to write");
    a_usb_flag_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
        ureq_q && !take_usb_w && !ctrl_wr_w |=> ureq_q)
        else $error("usb flag dropped");
    a_tmr_flag_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
        treq_q && !take_tmr_w && !ctrl_wr_w |=> treq_q)
        else $error("timer flag dropped");

    // Vectoring and entry side effects
    a_usb_vector: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        take_usb_w |=> irq_call && irq_vector == PC_W'(`UTIC_VEC_USB) && !gie_q)
        else $error("usb vector");
    a_tmr_vector: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        take_tmr_w |=> irq_call && irq_vector == PC_W'(`UTIC_VEC_TMR) && !gie_q)
        else $error("tmr vector");
    a_entry_clears: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
        take_usb_w && !usb_event_w |=> !ureq_q && !gie_q)
        else $error("entry clear");
    a_tmr_entry_clears: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
        take_tmr_w && !timer_overflow |=> !treq_q && !gie_q)
        else $error("timer entry clear");
    a_push_pc: assert property (@(posedge clk) disable iff (!arst_n) // RULE20
        ack_w |=> push_pc == $past(pc_cur))
        else $error("pushed pc");
    a_vector_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        !ack_w |=> $stable(irq_vector))
        else $error("vector moved");

    // Arbitration, gating and timing
    a_priority_usb: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
        ack_w && usb_rdy_w |-> take_usb_w)
        else $error("priority");
    a_both_usb_first: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
        ack_w && usb_rdy_w && tmr_rdy_w && !ctrl_wr_w |=> irq_vector == PC_W'(`UTIC_VEC_USB) && treq_q)
        else $error("timer not left pending");
    a_full_blocks: assert property (@(posedge clk) disable iff (!arst_n) // RULE19
        stack_full |=> !irq_call)
        else $error("ack on full stack");
    a_gate_enable: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        irq_call |-> $past(gie_q))
        else $error("ack while disabled");
    a_usb_gate: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        irq_call && irq_vector == PC_W'(`UTIC_VEC_USB) |-> $past(uie_q))
        else $error("usb ack while masked");
    a_tmr_gate: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
        irq_call && irq_vector == PC_W'(`UTIC_VEC_TMR) |-> $past(tie_q))
        else $error("timer ack while masked");
    a_phase_ack: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        irq_call |-> $past(phase_two_pulse))
        else $error("off-phase ack");
    a_pending_ack: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        phase_two_pulse && !stack_full && (usb_rdy_w || tmr_rdy_w) |=> irq_call)
        else $error("enabled request not serviced");
    a_call_single: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        irq_call |=> !irq_call)
        else $error("call wider than one cycle");
    a_phase_gap: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
        gap_q < 8'(`UTIC_PHASE_DIV))
        else $error("phase pulse missing");

    // Enable handling and readback
    a_return_enable_irq_sets: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        ret_enable_exec && !ack_w |=> gie_q)
        else $error("return-enable");
    a_plain_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
        !ret_enable_exec && !ack_w && !ctrl_wr_w |=> gie_q == $past(gie_q))
        else $error("global enable moved");
    a_write_enables: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
        ctrl_wr_w |=> uie_q == $past(mem_wdata[`UTIC_BIT_UIE]) && tie_q == $past(mem_wdata[`UTIC_BIT_TIE]))
        else $error("source enable write");
    a_rdata_unused: assert property (@(posedge clk) disable iff (!arst_n) // RULE16
        (irq_ctrl_rdata & 8'hA4) == 8'h00)
        else $error("unused bits read nonzero");

    // USB status bits
    a_fifo_sticky: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        fifo_q[0] && !fifo_flag_clr[0] |=> fifo_q[0])
        else $error("fifo flag dropped");
    a_fifo_set: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        |fifo_access |=> (fifo_access_flags & $past(fifo_access)) == $past(fifo_access))
        else $error("fifo flag not set");
    a_fifo_clear: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        fifo_q[0] && fifo_flag_clr[0] && !fifo_access[0] |=> !fifo_access_flags[0])
        else $error("fifo flag not cleared");
    a_busrst_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        usb_bus_reset |=> usb_status_control[`UTIC_USC_BUSRST])
        else $error("bus reset flag");
    a_busrst_sticky: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        brst_q && !bus_reset_clr |=> usb_status_control[`UTIC_USC_BUSRST])
        else $error("bus reset flag dropped");
    a_susp_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        usb_suspend |=> usb_status_control[`UTIC_USC_SUSPEND])
        else $error("suspend flag");
    a_resume_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        usb_resume |=> usb_status_control[`UTIC_USC_RESUME])
        else $error("resume flag");

    // Main scenarios
    c_usb_call: cover property (@(posedge clk) take_usb_w);
    c_tmr_call: cover property (@(posedge clk) take_tmr_w);
    c_both_pending: cover property (@(posedge clk) ack_w && usb_rdy_w && tmr_rdy_w);
    c_full_hold: cover property (@(posedge clk) phase_two_pulse && stack_full && usb_rdy_w);
    c_return_enable_irq_reenable: cover property (@(posedge clk) ret_enable_exec ##1 gie_q);
endmodule // utic_irq_ctrl

/* File: tb/utic_core_model.sv */
`timescale 1ns/1ps
// ==========================================
// Core model: pushes on call, returns after a short service
module utic_core_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic irq_call,
    input wire logic [10:0] irq_vector,
    input wire logic deep,
    input wire logic auto_ret,
    output logic stack_full,
    output logic ret_enable_exec,
    output logic [10:0] pc_cur
);
    logic [2:0] depth_q;
    logic [3:0] svc_q;
    // Deep fakes a stack already filled by earlier calls
    assign stack_full = (depth_q == 3'h4) | deep;
    // Service runs without nested calls, only the PC is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            depth_q <= 3'h0;
            svc_q <= 4'h0;
            pc_cur <= 11'h000;
            ret_enable_exec <= 1'b0;
        end else begin
            ret_enable_exec <= 1'b0;
            pc_cur <= irq_call ? irq_vector : pc_cur + 11'h001;
            if (irq_call) begin
                depth_q <= depth_q + 3'h1;
                svc_q <= 4'h8;
            end else if (svc_q != 4'h0) begin
                svc_q <= svc_q - 4'h1;
                if (svc_q == 4'h1 && auto_ret) begin
                    ret_enable_exec <= 1'b1;
                    depth_q <= depth_q - 3'h1;
                end
            end
        end
    end
endmodule // utic_core_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk, arst_n, mem_wr, irq_call, irq_ctrl_sel, stack_full, ret_enable_exec, deep, auto_ret;
    logic [7:0] mem_addr, mem_wdata, irq_ctrl_rdata, d;
    logic [1:0] fifo_flag_clr, fifo_access, fifo_access_flags;
    logic bus_reset_clr, suspend_clr, resume_clr, usb_suspend, usb_resume, usb_bus_reset, timer_overflow;
    logic [10:0] pc_cur, irq_vector, push_pc;
    logic [3:0] usb_status_control;
    int mismatches, checks, n;
    utic_irq_ctrl dut (.clk, .arst_n, .mem_addr, .mem_wr, .mem_wdata, .irq_ctrl_rdata, .irq_ctrl_sel,
        .fifo_flag_clr, .bus_reset_clr, .suspend_clr, .resume_clr, .fifo_access, .usb_suspend, .usb_resume,
        .usb_bus_reset, .timer_overflow, .stack_full, .ret_enable_exec, .pc_cur, .irq_call, .irq_vector,
        .push_pc, .fifo_access_flags, .usb_status_control);
    utic_core_model core (.clk, .arst_n, .irq_call, .irq_vector, .deep, .auto_ret, .stack_full,
        .ret_enable_exec, .pc_cur);
    // ==========================================
    // Clock and helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) {mem_addr, mem_wdata, mem_wr} = {a, v, 1'b1};
        @(negedge clk) mem_wr = 1'b0;
    endtask
    task rd(input logic [7:0] exp);
        mem_addr = 8'h0B;
        #1 chk({2'b0, irq_ctrl_sel, irq_ctrl_rdata}, {3'b001, exp}, "control read");
    endtask
    task no_call(input int c);
        repeat (c) @(negedge clk) if (irq_call !== 1'b0) chk(irq_call, 0, "unexpected call");
    endtask
    task wait_call(input logic [10:0] v);
        // Step past any call pulse already seen, so a back-to-back wait needs a fresh one
        @(negedge clk);
        for (n = 0; n < 60 && irq_call !== 1'b1; n++) @(negedge clk);
        if (n == 60) begin
            chk(1, 0, "call timeout");
            end_of_test;
        end
        chk(irq_vector, v, "vector");
        chk(push_pc, pc_cur - 11'h001, "pushed pc");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {arst_n, mem_addr, mem_wdata, mem_wr, fifo_flag_clr, fifo_access, deep, auto_ret} = '0;
        {bus_reset_clr, suspend_clr, resume_clr, usb_suspend, usb_resume, usb_bus_reset, timer_overflow} = '0;
        mismatches = 0;
        checks = 0;
        d = 8'($urandom(20148));
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        rd(8'h00);
        // Random writes with global enable off, unmapped neighbour ignored
        repeat (8) begin
            d = 8'($urandom) & 8'hFE;
            wr(8'h0B, d);
            wr(8'h0C, ~d);
            rd(d & 8'h5A);
        end
        wr(8'h0B, 8'h0A);
        @(negedge clk) {timer_overflow, usb_suspend} = 2'b11;
        @(negedge clk) {timer_overflow, usb_suspend} = 2'b00;
        no_call(12);
        rd(8'h5A);
        chk(usb_status_control[0], 1, "suspend bit");
        deep = 1'b1;
        auto_ret = 1'b1;
        wr(8'h0B, 8'h5B);
        no_call(12);
        deep = 1'b0;
        wait_call(11'h004);
        rd(8'h4A);
        wait_call(11'h00C);
        rd(8'h0A);
        no_call(12);
        rd(8'h0B);
        @(negedge clk) {fifo_access, usb_resume, usb_bus_reset} = 4'b1011;
        @(negedge clk) {fifo_access, usb_resume, usb_bus_reset} = 4'b0000;
        wait_call(11'h004);
        chk(fifo_access_flags, 2'b10, "fifo flags");
        chk(usb_status_control, 4'hD, "status bits");
        @(negedge clk) {fifo_flag_clr, bus_reset_clr, suspend_clr, resume_clr} = 5'h1F;
        @(negedge clk) {fifo_flag_clr, bus_reset_clr, suspend_clr, resume_clr} = 5'h00;
        chk({fifo_access_flags, usb_status_control}, 0, "status cleared");
        no_call(12);
        // Overflow in the same cycle as a clearing write
        @(negedge clk) {mem_addr, mem_wdata, mem_wr, timer_overflow} = {8'h0B, 8'h00, 2'b11};
        @(negedge clk) {mem_wr, timer_overflow} = 2'b00;
        rd(8'h40);
        end_of_test;
    end
endmodule // tb_top
